// ==== design/tmic_defs.vh ====
// Constants for the touch controller interrupt block
`ifndef TMIC_DEFS_VH
`define TMIC_DEFS_VH

`define TMIC_NSRC        24
`define TMIC_IDW         5
`define TMIC_AW          4
`define TMIC_DW          32
`define TMIC_A_FLAG      4'h0
`define TMIC_A_ENABLE    4'h1
`define TMIC_A_PRIO      4'h2
`define TMIC_A_TYPE      4'h3
`define TMIC_A_IRQSTAT   4'h4
`define TMIC_A_IRQMASK   4'h5
`define TMIC_A_ACTIVE    4'h6
`define TMIC_RST_24      24'h000000
`define TMIC_ACT_VALID   7
`define TMIC_ACT_HIGH    6
`define TMIC_EV_NEWREQ   0
`define TMIC_EV_OVERRUN  1
`define TMIC_NEV         2

`endif

// ==== design/tmic_pick.v ====
// Priority picker: lowest-index set bit of a request vector
`timescale 1ns/1ps
`default_nettype none
`include "tmic_defs.vh"
module tmic_pick
(
    input  wire [`TMIC_NSRC-1:0] req_in,
    output reg                   any_out,
    output reg  [`TMIC_IDW-1:0]  id_out
);
    integer i;

    // Scan from top so the lowest index wins
    always @*
    begin
        any_out = 1'b0;
        id_out  = {`TMIC_IDW{1'b0}};
        for (i = `TMIC_NSRC-1; i >= 0; i = i - 1)
        begin
            if (req_in[i])
            begin
                any_out = 1'b1;
                id_out  = i[`TMIC_IDW-1:0];
            end
        end
    end
endmodule
`default_nettype wire

// ==== design/tmic_top.v ====
// Interrupt controller: flags, enables, priorities and request selection
`timescale 1ns/1ps
`default_nettype none
`include "tmic_defs.vh"
module tmic_top
(
    input  wire                   clk_in,
    input  wire                   nrst_in,
    input  wire [`TMIC_NSRC-1:0]  src_in,
    input  wire [`TMIC_AW-1:0]    addr_in,
    input  wire [`TMIC_DW-1:0]    wdata_in,
    input  wire                   wr_in,
    input  wire                   rd_in,
    output reg  [`TMIC_DW-1:0]    rdata_out,
    output reg                    irq_req_out,
    output reg                    irq_high_out,
    output reg  [`TMIC_IDW-1:0]   irq_id_out,
    output reg                    irq_out
);
    reg  [`TMIC_NSRC-1:0] s1_r;
    reg  [`TMIC_NSRC-1:0] s2_r;
    reg  [`TMIC_NSRC-1:0] s3_r;
    reg  [`TMIC_NSRC-1:0] edge_flag_r;
    reg  [`TMIC_NSRC-1:0] enable_r;
    reg  [`TMIC_NSRC-1:0] prio_r;
    reg  [`TMIC_NSRC-1:0] type_r;
    reg  [`TMIC_NEV-1:0]  ev_stat_r;
    reg  [`TMIC_NEV-1:0]  ev_mask_r;
    reg                   req_prev_r;
    wire [`TMIC_NSRC-1:0] rise;
    wire [`TMIC_NSRC-1:0] flags;
    wire [`TMIC_NSRC-1:0] pend;
    wire [`TMIC_NSRC-1:0] pend_hi;
    wire                  any_hi;
    wire                  any_lo;
    wire [`TMIC_IDW-1:0]  id_hi;
    wire [`TMIC_IDW-1:0]  id_lo;
    wire [`TMIC_NSRC-1:0] flag_clr;
    wire [`TMIC_NEV-1:0]  ev_set;
    reg  [`TMIC_DW-1:0]   rdata_nxt;

    // Register write decode
    function wr_hit;
        input [`TMIC_AW-1:0] a;
        input [`TMIC_AW-1:0] b;
        begin
            wr_hit = (a == b);
        end
    endfunction

    // Presented source: high-priority pick first, else low
    function [`TMIC_IDW-1:0] sel_id;
        input                 hi;
        input [`TMIC_IDW-1:0] a;
        input [`TMIC_IDW-1:0] b;
        begin
            sel_id = hi ? a : b;
        end
    endfunction

    // Source lines come from other logic: two-stage synchroniser, third for edges
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            s1_r <= `TMIC_RST_24;
            s2_r <= `TMIC_RST_24;
            s3_r <= `TMIC_RST_24;
        end
        else
        begin
            s1_r <= src_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign rise     = s2_r & ~s3_r;
    assign flag_clr = (wr_in && wr_hit(addr_in, `TMIC_A_FLAG)) ?
                      wdata_in[`TMIC_NSRC-1:0] : `TMIC_RST_24;

    // Edge flags latch on a rising edge; set beats a clear in the same cycle
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            edge_flag_r <= `TMIC_RST_24;
        else
            edge_flag_r <= (edge_flag_r & ~flag_clr) | rise;
    end

    // Type 1 = edge, 0 = level; level flags mirror the synced line
    assign flags   = (type_r & edge_flag_r) | (~type_r & s2_r);
    assign pend    = flags & enable_r;
    assign pend_hi = pend & prio_r;

    tmic_pick u_pick_hi
    (
        .req_in  (pend_hi),
        .any_out (any_hi),
        .id_out  (id_hi)
    );

    tmic_pick u_pick_lo
    (
        .req_in  (pend),
        .any_out (any_lo),
        .id_out  (id_lo)
    );

    // Source enables: enabled alone means low priority
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            enable_r <= `TMIC_RST_24;
        else if (wr_in && wr_hit(addr_in, `TMIC_A_ENABLE))
            enable_r <= wdata_in[`TMIC_NSRC-1:0];
    end

    // Priority bits: only matter where the enable is set
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            prio_r <= `TMIC_RST_24;
        else if (wr_in && wr_hit(addr_in, `TMIC_A_PRIO))
            prio_r <= wdata_in[`TMIC_NSRC-1:0];
    end

    // Source type: all level after reset
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            type_r <= `TMIC_RST_24;
        else if (wr_in && wr_hit(addr_in, `TMIC_A_TYPE))
            type_r <= wdata_in[`TMIC_NSRC-1:0];
    end

    // Event mask for the summary interrupt
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            ev_mask_r <= {`TMIC_NEV{1'b0}};
        else if (wr_in && wr_hit(addr_in, `TMIC_A_IRQMASK))
            ev_mask_r <= wdata_in[`TMIC_NEV-1:0];
    end

    // Controller's own events: new request raised, and edge while flag already set
    assign ev_set[`TMIC_EV_NEWREQ]  = any_lo & ~req_prev_r;
    assign ev_set[`TMIC_EV_OVERRUN] = |(rise & edge_flag_r & type_r);

    // Previous request level, so only a rising request is an event
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            req_prev_r <= 1'b0;
        else
            req_prev_r <= any_lo;
    end

    // Sticky status, write one to clear, set wins
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ev_stat_r <= {`TMIC_NEV{1'b0}};
        end
        else
        begin
            if (wr_in && wr_hit(addr_in, `TMIC_A_IRQSTAT))
                ev_stat_r <= (ev_stat_r & ~wdata_in[`TMIC_NEV-1:0]) | ev_set;
            else
                ev_stat_r <= ev_stat_r | ev_set;
        end
    end

    // Processor-facing outputs, high priority chosen first
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            irq_req_out  <= 1'b0;
            irq_high_out <= 1'b0;
            irq_id_out   <= {`TMIC_IDW{1'b0}};
            irq_out      <= 1'b0;
        end
        else
        begin
            irq_req_out  <= any_lo;
            irq_high_out <= any_hi;
            irq_id_out   <= sel_id(any_hi, id_hi, id_lo);
            irq_out      <= |(ev_stat_r & ev_mask_r);
        end
    end

    // Read mux
    always @*
    begin
        rdata_nxt = {`TMIC_DW{1'b0}};
        case (addr_in)
            `TMIC_A_FLAG:    rdata_nxt[`TMIC_NSRC-1:0] = flags;
            `TMIC_A_ENABLE:  rdata_nxt[`TMIC_NSRC-1:0] = enable_r;
            `TMIC_A_PRIO:    rdata_nxt[`TMIC_NSRC-1:0] = prio_r;
            `TMIC_A_TYPE:    rdata_nxt[`TMIC_NSRC-1:0] = type_r;
            `TMIC_A_IRQSTAT: rdata_nxt[`TMIC_NEV-1:0]  = ev_stat_r;
            `TMIC_A_IRQMASK: rdata_nxt[`TMIC_NEV-1:0]  = ev_mask_r;
            `TMIC_A_ACTIVE:
            begin
                rdata_nxt[`TMIC_ACT_VALID] = any_lo;
                rdata_nxt[`TMIC_ACT_HIGH]  = any_hi;
                rdata_nxt[`TMIC_IDW-1:0]   = sel_id(any_hi, id_hi, id_lo);
            end
            default:         rdata_nxt = {`TMIC_DW{1'b0}};
        endcase
    end

    // Read data valid the cycle after the strobe only
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            rdata_out <= {`TMIC_DW{1'b0}};
        else if (rd_in)
            rdata_out <= rdata_nxt;
        else
            rdata_out <= {`TMIC_DW{1'b0}};
    end
endmodule
`default_nettype wire

// ==== verif/tmic_srcm.sv ====
// Interrupt source model driving the request lines
`timescale 1ns/1ps
`default_nettype none
module tmic_srcm
(
    input  wire logic        clk_in,
    input  wire logic [23:0] lvl_in,
    input  wire logic [23:0] pls_in,
    output wire logic [23:0] src_out
);
    logic [23:0] hold_r = 24'h0;
    // Stretch pulses so the synchroniser sees them
    always @(posedge clk_in) hold_r <= pls_in;
    // Level lines follow the owning module status
    assign src_out = lvl_in | pls_in | hold_r;
endmodule
`default_nettype wire

// ==== verif/tmic_monitor.sv ====
// Port checker for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tmic_monitor
(
    input wire logic        clk_in,
    input wire logic        nrst_in,
    input wire logic [3:0]  addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic        irq_req_out,
    input wire logic        irq_high_out,
    input wire logic [4:0]  irq_id_out,
    input wire logic        irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    property p_rdz; !$past(rd_in) |-> rdata_out == 32'h0; endproperty
    a_rdz: assert property (p_rdz) else $error("rdata idle");
    property p_idz; !irq_req_out |-> irq_id_out == 5'h0; endproperty
    a_idz: assert property (p_idz) else $error("id idle");
    property p_hi; irq_high_out |-> irq_req_out; endproperty
    a_hi: assert property (p_hi) else $error("high alone");
    property p_fl; $past(rd_in && addr_in == 4'h0) |-> rdata_out[31:24] == 8'h0; endproperty
    a_fl: assert property (p_fl) else $error("flag width");
    property p_pr; $past(wr_in && addr_in == 4'h2, 3) && $past(rd_in && addr_in == 4'h2)
        |-> rdata_out == {8'h0, $past(wdata_in[23:0], 3)}; endproperty
    a_pr: assert property (p_pr) else $error("prio readback");
    property p_off; wr_in && addr_in == 4'h1 && wdata_in == 32'h0 |-> ##[1:3] !irq_req_out;
    endproperty
    a_off: assert property (p_off) else $error("req while off");
    property p_msk; wr_in && addr_in == 4'h5 && wdata_in == 32'h0 |-> ##[1:3] !irq_out;
    endproperty
    a_msk: assert property (p_msk) else $error("irq masked");
    property p_unm; $past(rd_in && addr_in > 4'h6) |-> rdata_out == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    c_hi: cover property (irq_high_out);
    c_irq: cover property (irq_out);
    c_fall: cover property ($fell(irq_req_out));
endmodule
bind tmic_top tmic_monitor u_mon (.clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .irq_req_out, .irq_high_out, .irq_id_out, .irq_out);
`default_nettype wire

// ==== verif/tmic_top_tb.sv ====
// Testbench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "tmic_defs.vh"
module tmic_top_tb;
    logic        clk_in = 1'b0, nrst_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
    logic [3:0]  addr_in = 4'h0;
    logic [31:0] wdata_in = 32'h0;
    logic [23:0] lvl = 24'h0, pls = 24'h0;
    wire  [23:0] src;
    wire  [31:0] rdata_out;
    wire         irq_req_out, irq_high_out, irq_out;
    wire  [4:0]  irq_id_out;
    int          err_total = 0, n_compared = 0;
    // Clock
    initial forever #50 clk_in = ~clk_in;
    tmic_srcm srcm (.clk_in(clk_in), .lvl_in(lvl), .pls_in(pls), .src_out(src));
    tmic_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .src_in(src), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .irq_req_out(irq_req_out), .irq_high_out(irq_high_out), .irq_id_out(irq_id_out),
        .irq_out(irq_out));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    // Settle, then compare req, high and id
    task automatic ob(input logic [6:0] e);
        repeat (6) @(negedge clk_in);
        chk("irq", {25'h0, e}, {25'h0, irq_req_out, irq_high_out, irq_id_out});
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(negedge clk_in);
        chk("rdata", e, rdata_out);
    endtask
    task automatic t_level();
        rd(`TMIC_A_ENABLE, 32'h0);
        rd(4'hf, 32'h0);
        wr(`TMIC_A_ENABLE, 32'h8);
        lvl <= 24'h8;
        ob(7'h43);
        rd(`TMIC_A_FLAG, 32'h8);
        @(posedge clk_in);
        lvl <= 24'h0;
        ob(7'h00);
    endtask
    task automatic t_prio();
        wr(`TMIC_A_PRIO, 32'hffffffff);
        rd(`TMIC_A_PRIO, 32'h00ffffff);
        wr(`TMIC_A_ENABLE, 32'h204);
        wr(`TMIC_A_PRIO, 32'h200);
        lvl <= 24'h204;
        ob(7'h69);
        rd(`TMIC_A_ACTIVE, 32'hc9);
        wr(`TMIC_A_PRIO, 32'h0);
        ob(7'h42);
        wr(`TMIC_A_ENABLE, 32'h0);
        ob(7'h00);
        @(posedge clk_in);
        lvl <= 24'h0;
    endtask
    task automatic t_edge();
        rd(`TMIC_A_IRQSTAT, 32'h1);
        wr(`TMIC_A_IRQSTAT, 32'h3);
        rd(`TMIC_A_IRQSTAT, 32'h0);
        wr(`TMIC_A_TYPE, 32'h20);
        wr(`TMIC_A_ENABLE, 32'h20);
        wr(`TMIC_A_IRQMASK, 32'h1);
        rd(`TMIC_A_TYPE, 32'h20);
        rd(`TMIC_A_IRQMASK, 32'h1);
        chk("irq_out", 32'h0, {31'h0, irq_out});
        @(posedge clk_in);
        pls <= 24'h20;
        @(posedge clk_in);
        pls <= 24'h0;
        ob(7'h45);
        rd(`TMIC_A_FLAG, 32'h20);
        chk("irq_out", 32'h1, {31'h0, irq_out});
        @(posedge clk_in);
        pls <= 24'h20;
        @(posedge clk_in);
        pls <= 24'h0;
        ob(7'h45);
        rd(`TMIC_A_IRQSTAT, 32'h3);
        wr(`TMIC_A_FLAG, 32'h20);
        ob(7'h00);
        wr(`TMIC_A_IRQMASK, 32'h0);
        ob(7'h00);
        chk("irq_out", 32'h0, {31'h0, irq_out});
    endtask
    task automatic summarize();
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk_in);
        nrst_in <= 1'b1;
        t_level();
        t_prio();
        t_edge();
        summarize();
    end
    // Watchdog
    initial
    begin
        repeat (3000) @(posedge clk_in);
        err_total++;
        summarize();
    end
endmodule
`default_nettype wire
